/* File: inc/lmc_pkg.sv */
// Purpose: Shared constants and types for the single-wire bus transceiver
//          mode control.
// Assumes: 50 MHz system clock.
// Notes:   Enabling time is a plain default, kept as a named figure so
//          it can be retuned in one place.
package lmc_pkg;

	// ----------------------------------------------------------------
	// Mode field encoding
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_WAKE = 2'h1;
	localparam logic [1:0] MODE_RXONLY = 2'h2;
	localparam logic [1:0] MODE_NORMAL = 2'h3;
	localparam logic [1:0] MODE_RESET = MODE_OFF;

	// ----------------------------------------------------------------
	// Chip system modes
	// ----------------------------------------------------------------
	localparam logic [2:0] SYS_INIT = 3'h0;
	localparam logic [2:0] SYS_NORMAL = 3'h1;
	localparam logic [2:0] SYS_STOP = 3'h2;
	localparam logic [2:0] SYS_SLEEP = 3'h3;
	localparam logic [2:0] SYS_RESTART = 3'h4;
	localparam logic [2:0] SYS_FAILSAFE = 3'h5;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 50;
	localparam int EN_TIME_US = 10;
	localparam int EN_CYCLES = EN_TIME_US * CLK_MHZ;
	localparam int EN_CW = 10;
	localparam logic [EN_CW-1:0] EN_LAST = EN_CW'(EN_CYCLES - 1);

	typedef enum logic [1:0] {
		TX_IDLE,
		TX_ENABLING,
		TX_WAIT_HIGH,
		TX_ACTIVE
	} lmc_tx_state_t;

endpackage : lmc_pkg

/* File: rtl/lmc_en_timer.sv */
// Purpose: Enabling interval timer for the transceiver driver.
// Assumes: restart is a level held high while the interval must restart.
// Notes:   done stays high until restart or clear.
`timescale 1ns/1ns
module lmc_en_timer (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Control
	input wire logic restart,
	input wire logic run,
	// Status
	output logic done
);

	logic [lmc_pkg::EN_CW-1:0] cnt_q;
	logic [lmc_pkg::EN_CW-1:0] cnt_d;
	logic done_d;
	logic at_end;

	assign at_end = (cnt_q == lmc_pkg::EN_LAST);
	assign cnt_d = (restart || !run || done) ? '0 : cnt_q + 1'b1;
	assign done_d = run && !restart && (done || at_end);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
			done <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			done <= done_d;
		end
	end

endmodule : lmc_en_timer

/* File: rtl/lmc_mode_ctrl.sv */
// Purpose: Mode control of a single-wire bus transceiver in a system chip.
// Assumes: Configuration writes arrive as a one-cycle strobe with the mode
//          field; bus and host pins are synchronous to clock.
// Notes:   Analog slope control and the receive filter live elsewhere.
// How it works
// RL1: Power-up starts in off mode with bus activity stopped.
// RL2: Off mode can be selected and honoured in every system mode.
// RL3: In off mode bus wake activity changes nothing.
// RL4: Normal mode works only in normal or stop system mode.
// RL5: Host enables normal mode by a write in normal system mode.
// RL6: Operating mode follows the mode field written by configuration.
// RL7: Driver stays inactive for the enabling interval after normal is chosen.
// RL8: Host keeps transmit input high until the interval has elapsed.
// RL9: Dominant bits starting after the interval are sent, from the first one on.
// RL10: In normal mode the driver follows the transmit input.
// RL11: Receive output shows the received bus level, own bits included.
// RL12: Receive-only mode disables driver, keeps reception, in normal/stop.
// RL13: Wake mode encodes as 01 and still reads 01 after a wake.
// RL14: Enabling timer restarts on entering normal and clears otherwise.
// RL15: Input low at timer expiry keeps the bus recessive until seen high.
`timescale 1ns/1ns
module lmc_mode_ctrl (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Configuration port
	input wire logic cfg_wr,
	input wire logic [1:0] cfg_mode,
	output logic [1:0] transceiver_mode_field,
	// Chip state
	input wire logic [2:0] system_chip_mode,
	// Host pins
	input wire logic bus_transmit_input,
	output logic bus_receive_output,
	// Bus front end
	input wire logic bus_level,
	input wire logic bus_wake_seen,
	output logic bus_drive_dominant,
	output logic wake_flag
);

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	logic [1:0] mode_q;
	logic [1:0] mode_d;
	logic wake_q;
	logic wake_d;
	logic rx_allowed;
	logic normal_act;
	logic rxonly_act;
	logic wake_act;
	logic en_done;
	logic entering;
	logic normal_prev_q;
	lmc_pkg::lmc_tx_state_t st_q;
	lmc_pkg::lmc_tx_state_t st_d;

	function automatic logic sys_rx_ok(input logic [2:0] s);
		sys_rx_ok = (s == lmc_pkg::SYS_NORMAL) || (s == lmc_pkg::SYS_STOP);
	endfunction : sys_rx_ok

	assign rx_allowed = sys_rx_ok(system_chip_mode); // RL4
	assign mode_d = cfg_wr ? cfg_mode : mode_q; // RL6 RL2
	assign normal_act = (mode_q == lmc_pkg::MODE_NORMAL) && rx_allowed; // RL4
	assign rxonly_act = (mode_q == lmc_pkg::MODE_RXONLY) && rx_allowed; // RL12
	assign wake_act = (mode_q == lmc_pkg::MODE_WAKE); // RL13
	assign entering = normal_act && !normal_prev_q; // RL14
	// A wake counts only in wake mode; the mode field is left untouched.
	assign wake_d = wake_act && (wake_q || bus_wake_seen); // RL3 RL13
	assign transceiver_mode_field = mode_q; // RL13

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= lmc_pkg::MODE_RESET; // RL1
			wake_q <= 1'b0;
			normal_prev_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			wake_q <= wake_d;
			normal_prev_q <= normal_act;
		end
	end

	// ----------------------------------------------------------------
	// Enabling interval
	// ----------------------------------------------------------------
	lmc_en_timer u_timer (
		.clock(clock),
		.rst_n(rst_n),
		.restart(entering),
		.run(normal_act),
		.done(en_done)
	); // RL14 RL7

	// ----------------------------------------------------------------
	// Transmit gate
	// ----------------------------------------------------------------
	// A low input held across expiry is not sent, so a stuck host cannot
	// corrupt the first frame.
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			lmc_pkg::TX_IDLE:
				if (normal_act) st_d = lmc_pkg::TX_ENABLING;
			lmc_pkg::TX_ENABLING:
				if (en_done) begin
					st_d = bus_transmit_input ? lmc_pkg::TX_ACTIVE
						: lmc_pkg::TX_WAIT_HIGH; // RL15 RL9
				end
			lmc_pkg::TX_WAIT_HIGH:
				if (bus_transmit_input) st_d = lmc_pkg::TX_ACTIVE; // RL15
			lmc_pkg::TX_ACTIVE: ;
		endcase
		if (!normal_act || entering) begin
			st_d = normal_act ? lmc_pkg::TX_ENABLING
				: lmc_pkg::TX_IDLE; // RL14
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= lmc_pkg::TX_IDLE;
			bus_drive_dominant <= 1'b0;
			bus_receive_output <= 1'b1;
			wake_flag <= 1'b0;
		end else begin
			st_q <= st_d;
			bus_drive_dominant <= (st_d == lmc_pkg::TX_ACTIVE)
				&& !bus_transmit_input; // RL10 RL7
			bus_receive_output <= (normal_act || rxonly_act) ? bus_level
				: !wake_d; // RL11 RL3 RL12
			wake_flag <= wake_d;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_off_quiet;
		@(posedge clock) disable iff (!rst_n)
		(mode_q == lmc_pkg::MODE_OFF) |=> !bus_drive_dominant
			&& !wake_flag && bus_receive_output;
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("off not quiet"); // RL3

	property p_cfg;
		@(posedge clock) disable iff (!rst_n)
		cfg_wr |=> transceiver_mode_field == $past(cfg_mode);
	endproperty
	a_cfg: assert property (p_cfg) else $error("mode not taken"); // RL6

	property p_sys;
		@(posedge clock) disable iff (!rst_n)
		!rx_allowed |=> !bus_drive_dominant;
	endproperty
	a_sys: assert property (p_sys) else $error("driving in wrong mode"); // RL4

	property p_enable;
		@(posedge clock) disable iff (!rst_n)
		entering |-> !bus_drive_dominant [*8];
	endproperty
	a_enable: assert property (p_enable) else $error("drive too early"); // RL7

	property p_timer;
		@(posedge clock) disable iff (!rst_n)
		entering |-> ##1 !en_done;
	endproperty
	a_timer: assert property (p_timer) else $error("timer not restarted"); // RL14

	property p_hold;
		@(posedge clock) disable iff (!rst_n)
		(st_q == lmc_pkg::TX_WAIT_HIGH) |=> !bus_drive_dominant;
	endproperty
	a_hold: assert property (p_hold) else $error("stuck low sent"); // RL15

	property p_follow;
		@(posedge clock) disable iff (!rst_n)
		(st_q == lmc_pkg::TX_ACTIVE && normal_act && !entering)
			|=> bus_drive_dominant == !$past(bus_transmit_input);
	endproperty
	a_follow: assert property (p_follow) else $error("drive mismatch"); // RL10

	property p_rx;
		@(posedge clock) disable iff (!rst_n)
		(normal_act || rxonly_act) |=> bus_receive_output == $past(bus_level);
	endproperty
	a_rx: assert property (p_rx) else $error("rx mismatch"); // RL11

	property p_rxonly;
		@(posedge clock) disable iff (!rst_n)
		rxonly_act |=> !bus_drive_dominant;
	endproperty
	a_rxonly: assert property (p_rxonly) else $error("rx-only drives"); // RL12

	property p_wake;
		@(posedge clock) disable iff (!rst_n)
		(wake_act && bus_wake_seen && !cfg_wr) |=>
			wake_flag && transceiver_mode_field == lmc_pkg::MODE_WAKE;
	endproperty
	a_wake: assert property (p_wake) else $error("wake lost"); // RL13

	property p_wkrx;
		@(posedge clock) disable iff (!rst_n)
		wake_flag |-> !bus_receive_output;
	endproperty
	a_wkrx: assert property (p_wkrx) else $error("wake not shown"); // RL13

	property p_gate;
		@(posedge clock) disable iff (!rst_n)
		(st_q == lmc_pkg::TX_ENABLING) |=> !bus_drive_dominant;
	endproperty
	a_gate: assert property (p_gate) else $error("drive in enabling"); // RL7

	property p_tclr;
		@(posedge clock) disable iff (!rst_n)
		!normal_act |=> !en_done;
	endproperty
	a_tclr: assert property (p_tclr) else $error("timer kept"); // RL14

	property p_first;
		@(posedge clock) disable iff (!rst_n)
		(st_q == lmc_pkg::TX_WAIT_HIGH && bus_transmit_input && normal_act
			&& !entering) |=> st_q == lmc_pkg::TX_ACTIVE;
	endproperty
	a_first: assert property (p_first) else $error("first bit lost"); // RL9

	property p_keep;
		@(posedge clock) disable iff (!rst_n)
		!cfg_wr |=> $stable(transceiver_mode_field);
	endproperty
	a_keep: assert property (p_keep) else $error("field drifted"); // RL6

endmodule : lmc_mode_ctrl

/* File: verif/lmc_bus_partner.sv */
// Purpose: Single bus wire with a pull-up and one remote node.
// Assumes: Dominant is low on the wire.
// Notes: A released wire returns to its pull-up level.
`timescale 1ns/1ns
module lmc_bus_partner (
	// Drivers
	input wire logic drive_dom,
	input wire logic remote_dom,
	// Wire
	output logic bus_level
);
	assign bus_level = !(drive_dom | remote_dom);
endmodule : lmc_bus_partner

/* File: verif/lmc_mode_ctrl_tb.sv */
// Purpose: Self-checking bench for the transceiver mode control.
// Assumes: Enabling interval of 500 cycles.
// Notes: Checks are queued and judged at the next falling edge.
`timescale 1ns/1ns
`define CMP(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module lmc_mode_ctrl_tb;
	logic clock = 0, rst_n = 0, cfg_wr = 0, tx = 1, wake_seen = 0, rdom = 0;
	logic [1:0] cfg_mode = 2'h0;
	logic [2:0] sys = 3'h1;
	logic [1:0] field, v, w;
	logic rx, drv, wflag, bus;
	int fails = 0, n_tests = 0, cyc = 0;
	int s;
	int q_sel[$];
	logic [1:0] q_val[$];
	logic [2:0] bad[4] = '{3'h0, 3'h3, 3'h4, 3'h5};
	lmc_mode_ctrl uut (.clock(clock), .rst_n(rst_n), .cfg_wr(cfg_wr),
		.cfg_mode(cfg_mode), .transceiver_mode_field(field),
		.system_chip_mode(sys), .bus_transmit_input(tx),
		.bus_receive_output(rx), .bus_level(bus),
		.bus_wake_seen(wake_seen), .bus_drive_dominant(drv),
		.wake_flag(wflag));
	lmc_bus_partner far (.drive_dom(drv), .remote_dom(rdom), .bus_level(bus));
	initial forever #10 clock = ~clock;
	task summarize;
		$display("fails=%0d n_tests=%0d", fails, n_tests);
		if (fails == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize
	task tick(input int n);
		repeat (n) @(posedge clock);
	endtask : tick
	task note_exp(input int sel, input logic [1:0] val);
		q_sel.push_back(sel);
		q_val.push_back(val);
	endtask : note_exp
	task write(input logic [1:0] m);
		cfg_mode <= m;
		cfg_wr <= 1'b1;
		tick(1);
		cfg_wr <= 1'b0;
		tick(2);
	endtask : write
	always @(negedge clock) begin
		while (q_sel.size() > 0) begin
			s = q_sel.pop_front();
			v = (s == 0) ? field : (s == 1) ? {1'b0, drv} :
				(s == 2) ? {1'b0, rx} : {1'b0, wflag};
			w = q_val.pop_front();
			`CMP(v, w)
		end
	end
	// A hang is cut short well beyond the planned run length.
	always @(posedge clock) begin
		cyc++;
		if (cyc == 30000) begin
			fails++;
			summarize();
		end
	end
	initial begin
		void'($urandom(32'h8871586b));
		tick(20);
		rst_n <= 1'b1;
		note_exp(0, 2'h0);
		note_exp(1, 2'h0);
		note_exp(2, 2'h1);
		note_exp(3, 2'h0);
		tick(1);
		// Off is written in every system mode while a wake is pending.
		for (int m = 0; m < 6; m++) begin
			sys <= 3'(m);
			wake_seen <= 1'b1;
			tx <= 1'b0;
			write(2'h0);
			wake_seen <= 1'b0;
			tick(1);
			note_exp(0, 2'h0);
			note_exp(3, 2'h0);
			note_exp(2, 2'h1);
			note_exp(1, 2'h0);
		end
		tx <= 1'b1;
		foreach (bad[i]) begin
			sys <= bad[i];
			write(2'h3);
			tick(520);
			tx <= 1'b0;
			tick(3);
			note_exp(0, 2'h3);
			note_exp(1, 2'h0);
			note_exp(2, 2'h1);
			tx <= 1'b1;
		end
		sys <= 3'h2;
		write(2'h2);
		tx <= 1'b0;
		repeat (8) begin
			rdom <= 1'($urandom);
			tick(2);
			note_exp(1, 2'h0);
			note_exp(2, {1'b0, !rdom});
		end
		rdom <= 1'b0;
		write(2'h1);
		wake_seen <= 1'b1;
		tick(1);
		wake_seen <= 1'b0;
		tick(1);
		note_exp(3, 2'h1);
		note_exp(2, 2'h0);
		note_exp(0, 2'h1);
		write(2'h0);
		note_exp(3, 2'h0);
		note_exp(2, 2'h1);
		sys <= 3'h1;
		tx <= 1'b1;
		write(2'h3);
		tick(10);
		tx <= 1'b0;
		tick(470);
		note_exp(1, 2'h0);
		tick(40);
		note_exp(1, 2'h0);
		note_exp(2, 2'h1);
		tx <= 1'b1;
		tick(3);
		note_exp(1, 2'h0);
		repeat (20) begin
			tx <= 1'($urandom);
			tick(2);
			note_exp(1, {1'b0, !tx});
			note_exp(2, {1'b0, tx});
		end
		tx <= 1'b1;
		write(2'h2);
		write(2'h3);
		tick(100);
		tx <= 1'b0;
		tick(3);
		note_exp(1, 2'h0);
		tx <= 1'b1;
		tick(500);
		tx <= 1'b0;
		tick(3);
		note_exp(1, 2'h1);
		tick(2);
		summarize();
	end
endmodule : lmc_mode_ctrl_tb
